// ---- common/iod_pkg.sv ----
// constants and types for the isa opcode decoder
`default_nettype none
package iod_pkg;
  localparam int unsigned OSC_PER_CYCLE = 4;
  localparam logic [1:0] Q_LAST = 2'(OSC_PER_CYCLE - 1);
  // register byte addresses
  localparam logic [7:0] A_INSTR = 8'h00;
  localparam logic [7:0] A_ACC = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_PC = 8'h0C;
  localparam logic [7:0] A_FADDR = 8'h10;
  localparam logic [7:0] A_FDATA = 8'h14;
  localparam logic [7:0] A_CTRL = 8'h18;
  localparam logic [7:0] A_INFO = 8'h1C;
  // opcode groups
  localparam logic [1:0] G_BYTE = 2'h0;
  localparam logic [1:0] G_BIT = 2'h1;
  localparam logic [1:0] G_JUMP = 2'h2;
  localparam logic [1:0] G_LIT = 2'h3;
  // byte group operation codes
  localparam logic [3:0] B_MOVE_ACC = 4'h0;
  localparam logic [3:0] B_CLEAR = 4'h1;
  localparam logic [3:0] B_SUB = 4'h2;
  localparam logic [3:0] B_DEC = 4'h3;
  localparam logic [3:0] B_OR = 4'h4;
  localparam logic [3:0] B_AND = 4'h5;
  localparam logic [3:0] B_XOR = 4'h6;
  localparam logic [3:0] B_ADD = 4'h7;
  localparam logic [3:0] B_MOVE = 4'h8;
  localparam logic [3:0] B_COMP = 4'h9;
  localparam logic [3:0] B_INC = 4'hA;
  localparam logic [3:0] B_DEC_SKIP = 4'hB;
  localparam logic [3:0] B_ROR = 4'hC;
  localparam logic [3:0] B_ROL = 4'hD;
  localparam logic [3:0] B_SWAP = 4'hE;
  localparam logic [3:0] B_INC_SKIP = 4'hF;
  // bit group codes, opcode bits 11:10
  localparam logic [1:0] T_CLR = 2'h0;
  localparam logic [1:0] T_SET = 2'h1;
  localparam logic [1:0] T_SKIP_CLR = 2'h2;
  localparam logic [1:0] T_SKIP_SET = 2'h3;
  // literal group codes
  localparam logic [1:0] L_MOVE = 2'h0;
  localparam logic [1:0] L_RET = 2'h1;
  localparam logic [3:0] L_OR = 4'h8;
  localparam logic [3:0] L_AND = 4'h9;
  localparam logic [3:0] L_XOR = 4'hA;
  localparam logic [2:0] L_SUB = 3'h6;
  localparam logic [2:0] L_ADD = 3'h7;
  // whole-word control opcodes
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_RETINT = 14'h0009;
  localparam logic [13:0] OP_STANDBY = 14'h0063;
  localparam logic [13:0] OP_WDCLR = 14'h0064;
  // special file addresses
  localparam logic [6:0] FILE_TIMER = 7'h01;
  localparam logic [6:0] FILE_PORT = 7'h06;
  localparam int unsigned FILE_DEPTH = 128;
  localparam int unsigned STACK_DEPTH = 8;
  // status, control and info bit positions
  localparam int unsigned ST_C_BIT = 0;
  localparam int unsigned ST_DC_BIT = 1;
  localparam int unsigned ST_Z_BIT = 2;
  localparam int unsigned CTRL_PSA_BIT = 0;
  localparam int unsigned INFO_SBY_BIT = 0;
  localparam int unsigned INFO_TWO_BIT = 1;
  typedef struct packed {
    logic to;
    logic pd;
    logic z;
    logic dc;
    logic c;
  } iod_status_s;
  localparam iod_status_s STATUS_RST = 5'h18;
  typedef struct packed {
    iod_status_s st;
    logic [7:0] res;
    logic wr_acc;
    logic wr_file;
    logic upd_z;
    logic skip;
    logic jump;
    logic push;
    logic pop;
    logic tmr;
    logic sleep;
    logic [10:0] tgt;
  } iod_alu_s;
  typedef enum logic [2:0] {
    S_IDLE = 3'h1,
    S_EXEC = 3'h2,
    S_NOP = 3'h4
  } iod_state_e;
endpackage
`default_nettype wire

// ---- tb/iod_core_assertions.sv ----
// port checker for the opcode decoder core, bound to the core
`default_nettype none
module iod_core_checker import iod_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] port_pins,
  input wire logic [7:0] port_latch,
  input wire logic standby
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [13:0] last_op;
  logic [7:0] cnt;
  logic first;
  wire launch = psel && penable && pwrite && pready && paddr == A_INSTR;
  wire is_br = last_op[13:12] == 2'h2 || last_op[13:10] == 4'hD;
  // clocks since launch; saturates so a long idle never wraps to small
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_op <= 14'h0000;
      cnt <= 8'h00;
      first <= 1'h0;
    end else begin
      if (launch) last_op <= pwdata[13:0];
      if (launch) cnt <= 8'h00;
      else if (cnt != 8'hFF) cnt <= cnt + 8'h01;
      if (pready) first <= launch;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence seq_setup;
    psel && !penable;
  endsequence
  sequence seq_access;
    psel && penable;
  endsequence
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  AST_ERR_ONLY_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_ERR_UNMAPPED: assert property (pready && (paddr[1:0] != 2'h0 ||
    paddr > A_INFO) |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_MAPPED_OK: assert property (pready && paddr[1:0] == 2'h0 &&
    paddr <= A_INFO |-> !pslverr)
    else $error("mapped access refused");
  AST_ANSWER_BOUND: assert property (seq_setup ##1 seq_access |->
    ##[1:12] pready)
    else $error("no answer in time");
  AST_ONE_CYCLE_MIN: assert property (pready && first |-> cnt >= 8'h04)
    else $error("instruction finished in under four clocks");
  AST_BRANCH_TWO: assert property (pready && first && is_br |->
    cnt >= 8'h08)
    else $error("branch finished in under two cycles");
  AST_STANDBY_CAUSE: assert property ($rose(standby) |->
    last_op == OP_STANDBY)
    else $error("standby without standby opcode");
  AST_STANDBY_CLEAR: assert property (launch && standby &&
    pwdata[13:0] != OP_STANDBY |-> ##[1:5] !standby)
    else $error("standby not cleared by next opcode");
endmodule // iod_core_checker
bind iod_core iod_core_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .port_pins(port_pins), .port_latch(port_latch), .standby(standby));
`default_nettype wire

// ---- tb/iod_core_bench.sv ----
// self-checking bench driving the decoder core over apb
`default_nettype none
module iod_core_bench import iod_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] port_pins = 8'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] port_latch;
  logic standby;
  logic [4:0] pidx = 5'h00;
  logic [13:0] pword;
  logic [31:0] rd;
  logic er;
  logic [6:0] fa = 7'h20;
  int n_fail = 0;
  int checks_done = 0;
  iod_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_pins(port_pins), .port_latch(port_latch), .standby(standby));
  iod_prog_mem u_mem (.idx(pidx), .word(pword));
  always #10 pclk = ~pclk;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  // no cycle limit here: only the watchdog ends a stuck wait
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // load operands, launch one fetched word, then read back acc, file data, z/dc/c flags, two-cycle bit and pc
  task automatic run(input logic [4:0] i, input logic [7:0] a0, f0,
    input logic [2:0] s0, input logic [7:0] ea, ef,
    input logic [2:0] es, input logic two, input logic [10:0] epc);
    pidx = i;
    apb(1'h1, A_ACC, {24'h0, a0});
    apb(1'h1, A_STATUS, {29'h0, s0});
    apb(1'h1, A_FADDR, {25'h0, fa});
    apb(1'h1, A_FDATA, {24'h0, f0});
    apb(1'h1, A_PC, 32'h0);
    apb(1'h1, A_INSTR, {18'h0, pword});
    apb(1'h0, A_ACC, 32'h0);
    chk(rd, {24'h0, ea});
    apb(1'h0, A_FDATA, 32'h0);
    chk(rd, {24'h0, ef});
    apb(1'h0, A_STATUS, 32'h0);
    chk({29'h0, rd[2:0]}, {29'h0, es});
    apb(1'h0, A_INFO, 32'h0);
    chk({31'h0, rd[1]}, {31'h0, two});
    apb(1'h0, A_PC, 32'h0);
    chk(rd, {21'h0, epc});
  endtask
  // hang guard, far beyond the expected run length
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, A_STATUS, 32'h0);
    chk(rd, 32'h18);
    apb(1'h0, A_ACC, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 8'h20, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'h1, 8'h06, 32'hFF);
    chk({31'h0, er}, 32'h1);
    apb(1'h1, A_CTRL, 32'h1);
    run(5'h00, 8'h11, 8'h01, 3'h0, 8'h11, 8'h00, 3'h0, 1'h1, 11'h2);
    run(5'h01, 8'h00, 8'h05, 3'h7, 8'h04, 8'h05, 3'h7, 1'h0, 11'h1);
    run(5'h02, 8'h22, 8'hFF, 3'h0, 8'h22, 8'h00, 3'h0, 1'h1, 11'h2);
    run(5'h03, 8'h33, 8'h81, 3'h6, 8'h33, 8'h02, 3'h7, 1'h0, 11'h1);
    run(5'h04, 8'h44, 8'h01, 3'h5, 8'h80, 8'h01, 3'h5, 1'h0, 11'h1);
    run(5'h05, 8'h5A, 8'h5A, 3'h3, 8'h5A, 8'h00, 3'h7, 1'h0, 11'h1);
    run(5'h06, 8'h0F, 8'hF0, 3'h7, 8'hFF, 8'hF0, 3'h3, 1'h0, 11'h1);
    run(5'h07, 8'h00, 8'h99, 3'h2, 8'h00, 8'h99, 3'h6, 1'h0, 11'h1);
    run(5'h08, 8'h3C, 8'h99, 3'h1, 8'h00, 8'h99, 3'h5, 1'h0, 11'h1);
    run(5'h09, 8'h01, 8'h99, 3'h6, 8'h0F, 8'h99, 3'h1, 1'h0, 11'h1);
    run(5'h0A, 8'h20, 8'h99, 3'h0, 8'hF0, 8'h99, 3'h2, 1'h0, 11'h1);
    run(5'h0B, 8'h11, 8'hF7, 3'h7, 8'h11, 8'hF7, 3'h7, 1'h1, 11'h2);
    run(5'h0C, 8'h11, 8'hF7, 3'h0, 8'h11, 8'hF7, 3'h0, 1'h0, 11'h1);
    run(5'h0C, 8'h11, 8'h08, 3'h0, 8'h11, 8'h08, 3'h0, 1'h1, 11'h2);
    run(5'h0D, 8'h11, 8'h00, 3'h5, 8'h11, 8'h80, 3'h5, 1'h0, 11'h1);
    run(5'h0E, 8'h11, 8'hFF, 3'h2, 8'h11, 8'hFE, 3'h2, 1'h0, 11'h1);
    run(5'h0F, 8'h66, 8'h77, 3'h5, 8'h66, 8'h77, 3'h5, 1'h0, 11'h1);
    run(5'h10, 8'h12, 8'h34, 3'h0, 8'h12, 8'h34, 3'h0, 1'h1, 11'h100);
    run(5'h11, 8'h12, 8'h34, 3'h0, 8'h77, 8'h34, 3'h0, 1'h1, 11'h1);
    fa = FILE_PORT;
    port_pins <= 8'h0F;
    run(5'h12, 8'h12, 8'hFF, 3'h7, 8'h12, 8'h0F, 3'h3, 1'h0, 11'h1);
    chk({24'h0, port_latch}, 32'h0F);
    fa = FILE_TIMER;
    run(5'h13, 8'h12, 8'h33, 3'h0, 8'h12, 8'h33, 3'h0, 1'h0, 11'h1);
    apb(1'h0, A_INFO, 32'h0);
    chk({24'h0, rd[15:8]}, 32'h0);
    fa = 7'h20;
    run(5'h14, 8'h12, 8'h34, 3'h0, 8'h12, 8'h34, 3'h0, 1'h0, 11'h1);
    chk({31'h0, standby}, 32'h1);
    apb(1'h0, A_INFO, 32'h0);
    chk({31'h0, rd[0]}, 32'h1);
    // standby sets the time-out bit and clears the power-down bit
    apb(1'h0, A_STATUS, 32'h0);
    chk({27'h0, rd[4:0]}, 32'h10);
    run(5'h0F, 8'h12, 8'h34, 3'h0, 8'h12, 8'h34, 3'h0, 1'h0, 11'h1);
    chk({31'h0, standby}, 32'h0);
    complete_run();
  end
endmodule // iod_core_bench
`default_nettype wire

// ---- tb/iod_prog_mem.sv ----
// program memory model feeding instruction words to the bench
`default_nettype none
module iod_prog_mem import iod_pkg::*; (
  input wire logic [4:0] idx,
  output logic [13:0] word
);
  timeunit 1ns;
  timeprecision 1ns;
  // fixed image; file operand 0x20 unless the word names a special file
  localparam logic [13:0] IMG [0:20] = '{14'h0BA0, 14'h0B20, 14'h0FA0,
    14'h0DA0, 14'h0C20, 14'h06A0, 14'h0420, 14'h3800, 14'h3A3C, 14'h3D10,
    14'h3C10, 14'h19A0, 14'h1DA0, 14'h17A0, 14'h1020, 14'h3B55, 14'h2100,
    14'h3477, 14'h0886, 14'h0881, OP_STANDBY};
  // past the end reads as a plain no-op word
  assign word = (idx < 5'h15) ? IMG[idx] : 14'h0000;
endmodule // iod_prog_mem
`default_nettype wire

// ---- verilog/iod_core.sv ----
// instruction decode and execute core with apb register access
//
// The address map and register access over APB are this design's own decisions.
`default_nettype none
module iod_core import iod_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port_pins,
  output logic [7:0] port_latch,
  output logic standby
);
  // one-hot mask for a bit index
  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    return 8'(8'h01 << idx);
  endfunction
  // returns {nibble carry, carry, sum}
  function automatic logic [9:0] add_flags(input logic [7:0] x,
    input logic [7:0] y, input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo = 5'(x[3:0]) + 5'(y[3:0]) + 5'(cin);
    full = 9'(x) + 9'(y) + 9'(cin);
    return {lo[4], full};
  endfunction

  iod_state_e state_reg;
  logic [1:0] q_reg;
  logic [13:0] op_reg;
  logic [7:0] acc_reg;
  iod_status_s st_reg;
  logic [10:0] pc_reg;
  logic [2:0] sp_reg;
  logic [6:0] faddr_reg;
  logic psa_reg;
  logic [7:0] presc_reg;
  logic sby_reg;
  logic two_reg;
  logic ack_reg;
  logic [31:0] prdata_reg;
  logic [7:0] mem [FILE_DEPTH];
  logic [10:0] stack [STACK_DEPTH];
  iod_alu_s a;

  // opcode fields
  wire logic [1:0] grp = op_reg[13:12];
  wire logic [3:0] sub = op_reg[11:8];
  wire logic dbit = op_reg[7];
  wire logic [6:0] fa = op_reg[6:0];
  wire logic [2:0] bidx = op_reg[9:7];
  wire logic [7:0] lit = op_reg[7:0];
  wire logic [7:0] mask = bit_mask(bidx);
  // port as operand reads the pins, so inputs driven low write back 0
  wire logic [7:0] fval = (fa == FILE_PORT) ? port_pins : mem[fa];
  wire logic [9:0] sum_fw = add_flags(fval, acc_reg, 1'h0);
  wire logic [9:0] dif_fw = add_flags(fval, ~acc_reg, 1'h1);
  wire logic [9:0] sum_lw = add_flags(lit, acc_reg, 1'h0);
  wire logic [9:0] dif_lw = add_flags(lit, ~acc_reg, 1'h1);
  wire logic [2:0] sp_dn = 3'(sp_reg - 3'h1);
  wire logic [10:0] pc_inc = 11'(pc_reg + 11'h001);
  wire logic cyc_end = (state_reg != S_IDLE) && (q_reg == Q_LAST);
  wire logic commit = (state_reg == S_EXEC) && (q_reg == Q_LAST);
  wire logic long_op = a.skip || a.jump;

  // apb decode; a wait state lets read data come from a flop
  wire logic acc_ph = psel && penable;
  wire logic bus_wr = acc_ph && pwrite && ack_reg;
  wire logic launch = bus_wr && (paddr == A_INSTR);
  wire logic mapped = (paddr[1:0] == 2'h0) && (paddr <= A_INFO);
  wire logic ack_next = acc_ph && (state_reg == S_IDLE) && !ack_reg;

  // read data mux
  logic [31:0] rmux;
  always_comb begin
    unique case (paddr)
      A_INSTR: rmux = 32'(op_reg);
      A_ACC: rmux = 32'(acc_reg);
      A_STATUS: rmux = 32'(st_reg);
      A_PC: rmux = 32'(pc_reg);
      A_FADDR: rmux = 32'(faddr_reg);
      A_FDATA: rmux = 32'(mem[faddr_reg]);
      A_CTRL: rmux = 32'(psa_reg);
      A_INFO: rmux = {16'h0000, presc_reg, 6'h00, two_reg, sby_reg};
      default: rmux = 32'h0000_0000;
    endcase
  end

  // operation decode and alu; the default result changes nothing
  always_comb begin
    a = '0;
    a.st = st_reg;
    a.res = fval;
    a.tgt = pc_inc;
    unique case (grp)
      G_BYTE: begin
        a.wr_file = dbit;
        a.wr_acc = !dbit;
        a.tmr = dbit && (fa == FILE_TIMER);
        unique case (sub)
          B_MOVE_ACC: begin
            a.res = acc_reg;
            a.wr_acc = 1'h0;
            if (!dbit) begin
              a.wr_file = 1'h0;
              if (op_reg == OP_RETURN || op_reg == OP_RETINT) begin
                a.jump = 1'h1;
                a.pop = 1'h1;
                a.tgt = stack[sp_dn];
              end
              if (op_reg == OP_STANDBY) begin
                a.sleep = 1'h1;
                a.st.to = 1'h1;
                a.st.pd = 1'h0;
              end
              if (op_reg == OP_WDCLR) begin
                a.st.to = 1'h1;
                a.st.pd = 1'h1;
              end
            end
          end
          B_CLEAR: begin
            a.res = 8'h00;
            a.upd_z = 1'h1;
          end
          B_SUB: begin
            {a.st.dc, a.st.c, a.res} = dif_fw;
            a.upd_z = 1'h1;
          end
          B_DEC: begin
            a.res = 8'(fval - 8'h01);
            a.upd_z = 1'h1;
          end
          B_OR: begin
            a.res = fval | acc_reg;
            a.upd_z = 1'h1;
          end
          B_AND: begin
            a.res = fval & acc_reg;
            a.upd_z = 1'h1;
          end
          B_XOR: begin
            a.res = fval ^ acc_reg;
            a.upd_z = 1'h1;
          end
          B_ADD: begin
            {a.st.dc, a.st.c, a.res} = sum_fw;
            a.upd_z = 1'h1;
          end
          B_MOVE: a.upd_z = 1'h1;
          B_COMP: begin
            a.res = ~fval;
            a.upd_z = 1'h1;
          end
          B_INC: begin
            a.res = 8'(fval + 8'h01);
            a.upd_z = 1'h1;
          end
          B_DEC_SKIP: begin
            a.res = 8'(fval - 8'h01);
            a.skip = (fval == 8'h01);
          end
          B_ROR: begin
            a.res = {st_reg.c, fval[7:1]};
            a.st.c = fval[0];
          end
          B_ROL: begin
            a.res = {fval[6:0], st_reg.c};
            a.st.c = fval[7];
          end
          B_SWAP: a.res = {fval[3:0], fval[7:4]};
          B_INC_SKIP: begin
            a.res = 8'(fval + 8'h01);
            a.skip = (fval == 8'hFF);
          end
        endcase
      end
      G_BIT: begin
        unique case (sub[3:2])
          T_CLR: begin
            a.res = fval & ~mask;
            a.wr_file = 1'h1;
            a.tmr = (fa == FILE_TIMER);
          end
          T_SET: begin
            a.res = fval | mask;
            a.wr_file = 1'h1;
            a.tmr = (fa == FILE_TIMER);
          end
          T_SKIP_CLR: a.skip = !(|(fval & mask));
          T_SKIP_SET: a.skip = |(fval & mask);
        endcase
      end
      G_JUMP: begin
        a.jump = 1'h1;
        a.push = !op_reg[11];
        a.tgt = op_reg[10:0];
      end
      G_LIT: begin
        a.res = lit;
        if (sub[3:2] == L_MOVE) begin
          a.wr_acc = 1'h1;
        end else if (sub[3:2] == L_RET) begin
          a.wr_acc = 1'h1;
          a.jump = 1'h1;
          a.pop = 1'h1;
          a.tgt = stack[sp_dn];
        end else if (sub == L_OR) begin
          a.res = lit | acc_reg;
          a.wr_acc = 1'h1;
          a.upd_z = 1'h1;
        end else if (sub == L_AND) begin
          a.res = lit & acc_reg;
          a.wr_acc = 1'h1;
          a.upd_z = 1'h1;
        end else if (sub == L_XOR) begin
          a.res = lit ^ acc_reg;
          a.wr_acc = 1'h1;
          a.upd_z = 1'h1;
        end else if (sub[3:1] == L_SUB) begin
          {a.st.dc, a.st.c, a.res} = dif_lw;
          a.wr_acc = 1'h1;
          a.upd_z = 1'h1;
        end else if (sub[3:1] == L_ADD) begin
          {a.st.dc, a.st.c, a.res} = sum_lw;
          a.wr_acc = 1'h1;
          a.upd_z = 1'h1;
        end
      end
    endcase
    // anything not matched above leaves a idle: a one-cycle no-op
    if (a.upd_z) begin
      a.st.z = (a.res == 8'h00);
    end
  end

  // instruction cycle sequencer; a taken branch or skip adds a no-op cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      q_reg <= 2'h0;
    end else begin
      q_reg <= (state_reg == S_IDLE) ? 2'h0 : 2'(q_reg + 2'h1);
      unique case (state_reg)
        S_IDLE: if (launch) state_reg <= S_EXEC;
        S_EXEC: if (commit) state_reg <= long_op ? S_NOP : S_IDLE;
        S_NOP: if (cyc_end) state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // core registers; bus writes only land while idle, so no overlap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_reg <= 14'h0000;
      acc_reg <= 8'h00;
      st_reg <= STATUS_RST;
      pc_reg <= 11'h000;
      sp_reg <= 3'h0;
      two_reg <= 1'h0;
    end else begin
      if (launch) op_reg <= pwdata[13:0];
      if (commit) begin
        st_reg <= a.st;
        two_reg <= long_op;
        if (a.wr_acc) acc_reg <= a.res;
        pc_reg <= a.jump ? a.tgt : pc_inc;
        if (a.push) sp_reg <= 3'(sp_reg + 3'h1);
        if (a.pop) sp_reg <= sp_dn;
      end else if (cyc_end) begin
        pc_reg <= (state_reg == S_NOP && !a.jump) ? pc_inc : pc_reg;
      end else if (bus_wr) begin
        if (paddr == A_ACC) acc_reg <= pwdata[7:0];
        if (paddr == A_PC) pc_reg <= pwdata[10:0];
        if (paddr == A_STATUS) begin
          st_reg.z <= pwdata[ST_Z_BIT];
          st_reg.dc <= pwdata[ST_DC_BIT];
          st_reg.c <= pwdata[ST_C_BIT];
        end
      end
    end
  end

  // return stack is plain data, so it carries no reset
  always_ff @(posedge pclk) begin
    if (commit && a.push) stack[sp_reg] <= pc_inc;
  end

  // file registers, written back whole after the operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < FILE_DEPTH; i++) mem[i] <= 8'h00;
    end else if (commit && a.wr_file) begin
      mem[fa] <= a.res;
    end else if (bus_wr && paddr == A_FDATA) begin
      mem[faddr_reg] <= pwdata[7:0];
    end
  end

  // prescaler counts instruction cycles; a timer write clears it first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_reg <= 8'h00;
    end else if (commit && a.tmr && psa_reg) begin
      presc_reg <= 8'h00;
    end else if (cyc_end && psa_reg) begin
      presc_reg <= 8'(presc_reg + 8'h01);
    end
  end

  // control, standby and bus handshake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      faddr_reg <= 7'h00;
      psa_reg <= 1'h0;
      sby_reg <= 1'h0;
      ack_reg <= 1'h0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= ack_next;
      if (ack_next) prdata_reg <= rmux;
      if (bus_wr && paddr == A_FADDR) faddr_reg <= pwdata[6:0];
      if (bus_wr && paddr == A_CTRL) psa_reg <= pwdata[CTRL_PSA_BIT];
      if (commit && a.sleep) sby_reg <= 1'h1;
      else if (launch) sby_reg <= 1'h0;
    end
  end

  assign pready = ack_reg;
  assign pslverr = ack_reg && !mapped;
  assign prdata = prdata_reg;
  assign port_latch = mem[FILE_PORT];
  assign standby = sby_reg;
endmodule // iod_core
`default_nettype wire
